//--- pmra_flag_cell.sv
// One limit flag, transparent or latched
`timescale 1ns/1ps
module pmra_flag_cell
  import pmra_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Control
  input  wire logic latch_en,
  input  wire logic strobe,
  input  wire logic cond,
  input  wire logic rd_clr,
  // Flag
  output logic      flag_r
);
  logic flag_nxt;

  // Latched: a new violation beats a read in the same cycle
  assign flag_nxt = latch_en ? ((strobe & cond) | (flag_r & ~rd_clr))
                             : (strobe ? cond : flag_r);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end
endmodule // pmra_flag_cell

//--- pmra_host_model.sv
// Host side model: register port master and pulled-up open-drain alert wire
`timescale 1ns/1ps
module pmra_host_model
  import pmra_pkg::*;
(
  // Clock
  input  wire logic               mclk,
  // Register port
  output logic      [5:0]         reg_addr,
  output logic                    reg_rd,
  output logic                    reg_wr,
  output logic      [15:0]        reg_wdata,
  input  wire logic [W_RDATA-1:0] reg_rdata_r,
  // Alert wire
  input  wire logic               alert_o_r,
  input  wire logic               alert_oe_r,
  output logic                    alert_pin
);
  // The bank only ever sinks the wire; the board pull-up gives the high level
  assign alert_pin = alert_oe_r ? alert_o_r : 1'b1;

  initial
  begin
    reg_addr  = 6'h00;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
  end

  ////////////////////////////////////////
  // Released lines show the inverse of the last value, so stale data never looks valid
  task automatic rd(input logic [5:0] a, output logic [W_RDATA-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata_r;
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule // pmra_host_model

//--- pmra_limit_cmp.sv
// Limit comparators producing the six violation conditions
`timescale 1ns/1ps
module pmra_limit_cmp
  import pmra_pkg::*;
(
  // Measured values
  input  wire logic [W_BUS_V-1:0] bus_v,
  input  wire logic [W_TEMP-1:0]  temp,
  input  wire logic [W_CURR-1:0]  curr,
  input  wire logic [W_POWER-1:0] power,
  // Thresholds
  input  wire logic [14:0]        bus_over_lim,
  input  wire logic [14:0]        bus_under_lim,
  input  wire logic [W_TEMP-1:0]  temp_over_lim,
  input  wire logic [W_CURR-1:0]  curr_over_lim,
  input  wire logic [W_CURR-1:0]  curr_under_lim,
  input  wire logic [15:0]        power_over_lim,
  // Violations, L_* order
  output logic      [N_LIM-1:0]   viol
);
  // Power threshold is coarser than the power result
  wire logic [W_POWER-1:0] pwr_lim_full = {power_over_lim, {PWR_LIM_SHIFT{1'b0}}};

  assign viol[L_TEMP_OVER]  = $signed(temp) > $signed(temp_over_lim);
  assign viol[L_CURR_OVER]  = $signed(curr) > $signed(curr_over_lim);
  assign viol[L_CURR_UNDER] = $signed(curr) < $signed(curr_under_lim);
  assign viol[L_BUS_OVER]   = bus_v > {1'b0, bus_over_lim};
  assign viol[L_BUS_UNDER]  = bus_v < {1'b0, bus_under_lim};
  assign viol[L_POWER]      = power > pwr_lim_full;
endmodule // pmra_limit_cmp

//--- pmra_pkg.sv
// Shared constants for the power monitor result and alert register bank
package pmra_pkg;
  // Register offsets on the register port
  localparam logic [5:0]  ADDR_BUS_V   = 6'h05;
  localparam logic [5:0]  ADDR_TEMP    = 6'h06;
  localparam logic [5:0]  ADDR_CURR    = 6'h07;
  localparam logic [5:0]  ADDR_POWER   = 6'h08;
  localparam logic [5:0]  ADDR_ENERGY  = 6'h09;
  localparam logic [5:0]  ADDR_CHARGE  = 6'h0A;
  localparam logic [5:0]  ADDR_DIAG    = 6'h0B;
  // Result widths
  localparam int          W_BUS_V      = 16;
  localparam int          W_TEMP       = 12;
  localparam int          W_CURR       = 16;
  localparam int          W_POWER      = 24;
  localparam int          W_ACC        = 40;
  localparam int          W_RDATA      = 40;
  localparam int          TEMP_LSB_POS = 4;
  localparam int          PWR_LIM_SHIFT = 8;
  // Diagnostic register field positions
  localparam int          B_LATCH      = 15;
  localparam int          B_CNV_ALERT  = 14;
  localparam int          B_AVG_CMP    = 13;
  localparam int          B_POL        = 12;
  localparam int          B_E_OVF      = 11;
  localparam int          B_Q_OVF      = 10;
  localparam int          B_MATH_OVF   = 9;
  localparam int          B_LIM_LO     = 2;
  localparam int          N_LIM        = 6;
  localparam int          B_CNV_DONE   = 1;
  localparam int          B_TRIM_OK    = 0;
  localparam logic [15:0] DIAG_RESET   = 16'h0001;
  // Limit flag order, bit index above B_LIM_LO
  localparam int          L_POWER      = 0;
  localparam int          L_BUS_UNDER  = 1;
  localparam int          L_BUS_OVER   = 2;
  localparam int          L_CURR_UNDER = 3;
  localparam int          L_CURR_OVER  = 4;
  localparam int          L_TEMP_OVER  = 5;
endpackage

//--- pmra_result_bank.sv
// Result registers, diagnostic flags and open-drain alert of the power monitor
//
// What this block does
// - Bus voltage result is 16-bit read-only, never negative, 3.125 mV per step.
// - Die temperature sits in bits 15..4, signed, 125 m°C per step; low bits zero.
// - Current result is 16-bit read-only signed, 2.4 mA per step.
// - Power result is 24-bit read-only unsigned, 480 µW per step.
// - Energy result is 40-bit read-only unsigned, 7.68 mJ per step.
// - Charge result is 40-bit read-only signed, 150 µC per step.
// - Transparent mode: alert and flags return idle once the fault is gone.
// - Latched mode: alert and flags hold after a fault until diagnostic read.
// - Bit 14 set lets conversion done drive the alert; clear, it does not.
// - Bit 13 picks raw results or averaged results for limit comparison.
// - Bit 12 sets alert polarity: 0 active-low, 1 active-high, both open-drain.
// - Bits 11 and 10 flag energy and charge wrap; cleared by accumulator clear.
// - Bit 9 flags arithmetic overflow; cleared by new conversion or accumulator clear.
// - Bit 7 sets when die temperature exceeds its over-limit.
// - Bit 6 sets when current exceeds its over-limit.
// - Bit 5 sets when current falls below its under-limit.
// - Bit 4 sets when bus voltage exceeds its over-limit.
// - Bit 3 sets when bus voltage falls below its under-limit.
// - Bit 2 sets when power exceeds its over-limit.
// - Latched mode: reading the diagnostic register clears bits 7..2.
// - Bit 1 sets on conversion done; latched, read or new conversion clears it.
// - Bit 0 resets to 1 and drops to 0 on a trim checksum error.
`timescale 1ns/1ps
module pmra_result_bank
  import pmra_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // Register port
  input  wire logic [5:0]         reg_addr,
  input  wire logic               reg_rd,
  input  wire logic               reg_wr,
  input  wire logic [15:0]        reg_wdata,
  output logic      [W_RDATA-1:0] reg_rdata_r,
  // Conversion engine events
  input  wire logic               raw_valid,
  input  wire logic               avg_done,
  input  wire logic               conv_trigger,
  input  wire logic               accumulator_clear,
  input  wire logic               energy_wrap,
  input  wire logic               charge_wrap,
  input  wire logic               math_ovf,
  input  wire logic               trim_checksum_err,
  // Conversion engine values
  input  wire logic [W_BUS_V-1:0] bus_v_in,
  input  wire logic [W_TEMP-1:0]  temp_in,
  input  wire logic [W_CURR-1:0]  curr_in,
  input  wire logic [W_POWER-1:0] power_in,
  input  wire logic [W_ACC-1:0]   energy_in,
  input  wire logic [W_ACC-1:0]   charge_in,
  // Thresholds
  input  wire logic [14:0]        bus_over_lim,
  input  wire logic [14:0]        bus_under_lim,
  input  wire logic [W_TEMP-1:0]  temp_over_lim,
  input  wire logic [W_CURR-1:0]  curr_over_lim,
  input  wire logic [W_CURR-1:0]  curr_under_lim,
  input  wire logic [15:0]        power_over_lim,
  // Open-drain alert pin
  output logic                    alert_o_r,
  output logic                    alert_oe_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [W_BUS_V-1:0] bus_voltage_result_r;
  logic [W_TEMP-1:0]  die_temperature_result_r;
  logic [W_CURR-1:0]  current_result_r;
  logic [W_POWER-1:0] power_result_r;
  logic [W_ACC-1:0]   energy_accumulator_r;
  logic [W_ACC-1:0]   charge_accumulator_r;
  logic               alert_latch_enable_r;
  logic               ready_on_alert_enable_r;
  logic               averaged_compare_select_r;
  logic               alert_sense_invert_r;
  logic               energy_overflow_flag_r;
  logic               charge_overflow_flag_r;
  logic               arithmetic_overflow_flag_r;
  logic               conversion_done_flag_r;
  logic               trim_checksum_ok_r;
  logic [N_LIM-1:0]   lim_flags;
  logic [N_LIM-1:0]   viol;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire logic diag_rd  = reg_rd & (reg_addr == ADDR_DIAG);
  wire logic diag_wr  = reg_wr & (reg_addr == ADDR_DIAG);
  wire logic rd_clr   = diag_rd & alert_latch_enable_r;
  // Comparison source: raw samples, or only the finished average
  wire logic cmp_strobe = averaged_compare_select_r ? avg_done : raw_valid;

  wire logic [15:0] diag_word = {alert_latch_enable_r, ready_on_alert_enable_r,
                                 averaged_compare_select_r, alert_sense_invert_r,
                                 energy_overflow_flag_r, charge_overflow_flag_r,
                                 arithmetic_overflow_flag_r, 1'b0, lim_flags,
                                 conversion_done_flag_r, trim_checksum_ok_r};

  // Temperature occupies the top twelve bits, low nibble fixed zero
  wire logic [15:0] temp_word = {die_temperature_result_r, {TEMP_LSB_POS{1'b0}}};

  // Narrow registers sit in the low bits, unmapped offsets read zero
  wire logic [W_RDATA-1:0] rd_mux =
      (reg_addr == ADDR_BUS_V)  ? {24'h00_0000, bus_voltage_result_r} :
      (reg_addr == ADDR_TEMP)   ? {24'h00_0000, temp_word} :
      (reg_addr == ADDR_CURR)   ? {24'h00_0000, current_result_r} :
      (reg_addr == ADDR_POWER)  ? {16'h0000, power_result_r} :
      (reg_addr == ADDR_ENERGY) ? energy_accumulator_r :
      (reg_addr == ADDR_CHARGE) ? charge_accumulator_r :
      (reg_addr == ADDR_DIAG)   ? {24'h00_0000, diag_word} : 40'h00_0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Limit comparison and flags
  pmra_limit_cmp u_cmp (
    .bus_v          (bus_v_in),
    .temp           (temp_in),
    .curr           (curr_in),
    .power          (power_in),
    .bus_over_lim   (bus_over_lim),
    .bus_under_lim  (bus_under_lim),
    .temp_over_lim  (temp_over_lim),
    .curr_over_lim  (curr_over_lim),
    .curr_under_lim (curr_under_lim),
    .power_over_lim (power_over_lim),
    .viol           (viol)
  );

  // Bits 7..2: temp over, curr over, curr under, bus over, bus under, power over
  genvar gi;
  generate
    for (gi = 0; gi < N_LIM; gi = gi + 1)
    begin : g_lim
      pmra_flag_cell u_flag (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .latch_en (alert_latch_enable_r),
        .strobe   (cmp_strobe),
        .cond     (viol[gi]),
        .rd_clr   (rd_clr),
        .flag_r   (lim_flags[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next values of status flags; a setting event always beats a clear
  wire logic cnv_nxt  = avg_done | (conversion_done_flag_r & ~rd_clr & ~conv_trigger);
  wire logic e_of_nxt = energy_wrap | (energy_overflow_flag_r & ~accumulator_clear);
  wire logic q_of_nxt = charge_wrap | (charge_overflow_flag_r & ~accumulator_clear);
  wire logic m_of_nxt = math_ovf |
                        (arithmetic_overflow_flag_r & ~conv_trigger & ~accumulator_clear);

  // Alert follows the flags, so transparent flags drop the pin with them
  wire logic alert_active = (|lim_flags) |
                            (ready_on_alert_enable_r & conversion_done_flag_r);
  // Open-drain: polarity 1 releases the pin while active and pulls low while idle
  wire logic alert_oe_nxt = alert_sense_invert_r ? ~alert_active : alert_active;

  ////////////////////////////////////////////////////////////////////////////
  // Result registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      bus_voltage_result_r     <= 16'h0000;
      die_temperature_result_r <= 12'h000;
      current_result_r         <= 16'h0000;
      power_result_r           <= 24'h00_0000;
    end
    else if (avg_done)
    begin
      bus_voltage_result_r     <= bus_v_in;
      die_temperature_result_r <= temp_in;
      current_result_r         <= curr_in;
      power_result_r           <= power_in;
    end
  end

  // Accumulators mirror the engine, and the clear wins the cycle it arrives
  always_ff @(posedge mclk)
  begin
    if (!rst_n || accumulator_clear)
    begin
      energy_accumulator_r <= 40'h00_0000_0000;
      charge_accumulator_r <= 40'h00_0000_0000;
    end
    else if (avg_done)
    begin
      energy_accumulator_r <= energy_in;
      charge_accumulator_r <= charge_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and status
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      alert_latch_enable_r      <= DIAG_RESET[B_LATCH];
      ready_on_alert_enable_r   <= DIAG_RESET[B_CNV_ALERT];
      averaged_compare_select_r <= DIAG_RESET[B_AVG_CMP];
      alert_sense_invert_r      <= DIAG_RESET[B_POL];
    end
    else if (diag_wr)
    begin
      alert_latch_enable_r      <= reg_wdata[B_LATCH];
      ready_on_alert_enable_r   <= reg_wdata[B_CNV_ALERT];
      averaged_compare_select_r <= reg_wdata[B_AVG_CMP];
      alert_sense_invert_r      <= reg_wdata[B_POL];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      energy_overflow_flag_r     <= DIAG_RESET[B_E_OVF];
      charge_overflow_flag_r     <= DIAG_RESET[B_Q_OVF];
      arithmetic_overflow_flag_r <= DIAG_RESET[B_MATH_OVF];
      conversion_done_flag_r     <= DIAG_RESET[B_CNV_DONE];
      trim_checksum_ok_r         <= DIAG_RESET[B_TRIM_OK];
    end
    else
    begin
      energy_overflow_flag_r     <= e_of_nxt;
      charge_overflow_flag_r     <= q_of_nxt;
      arithmetic_overflow_flag_r <= m_of_nxt;
      conversion_done_flag_r     <= cnv_nxt;
      // Sticky until reset: a corrupt trim stays reported
      trim_checksum_ok_r         <= trim_checksum_ok_r & ~trim_checksum_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and alert pin
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      reg_rdata_r <= 40'h00_0000_0000;
    else if (reg_rd)
      reg_rdata_r <= rd_mux;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      alert_o_r  <= 1'b0;
      alert_oe_r <= 1'b0;
    end
    else
    begin
      alert_o_r  <= 1'b0;
      alert_oe_r <= alert_oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_rd_clears_lim:
    assert property (@(posedge mclk) disable iff (!rst_n)
      (rd_clr && !cmp_strobe) |=> (lim_flags == 6'h00))
    else $error("latched limit flags not cleared by diagnostic read");

  a_latched_hold:
    assert property (@(posedge mclk) disable iff (!rst_n)
      (alert_latch_enable_r && lim_flags[L_CURR_OVER] && !diag_rd && !diag_wr)
        |=> lim_flags[L_CURR_OVER])
    else $error("latched overcurrent flag dropped without a read");

  a_transp_follow:
    assert property (@(posedge mclk) disable iff (!rst_n)
      (!alert_latch_enable_r && cmp_strobe) |=> (lim_flags == $past(viol)))
    else $error("transparent flags do not match the comparison");

  a_transp_idle:
    assert property (@(posedge mclk) disable iff (!rst_n)
      (!alert_latch_enable_r && !diag_wr && cmp_strobe && viol == 6'h00 && !alert_sense_invert_r
       && !ready_on_alert_enable_r) |=> ##1 !alert_oe_r)
    else $error("alert not released after fault cleared");

  a_cnv_alert:
    assert property (@(posedge mclk) disable iff (!rst_n)
      (conversion_done_flag_r && lim_flags == 6'h00 && !alert_sense_invert_r)
        |=> (alert_oe_r == $past(ready_on_alert_enable_r)))
    else $error("conversion done alert not gated by enable");

  a_pol_inverted:
    assert property (@(posedge mclk) disable iff (!rst_n)
      (alert_sense_invert_r && !alert_active) |=> alert_oe_r)
    else $error("inverted idle alert does not pull low");

  a_energy_ovf:
    assert property (@(posedge mclk) disable iff (!rst_n)
      energy_wrap |=> energy_overflow_flag_r ##1 (energy_overflow_flag_r || $past(accumulator_clear)))
    else $error("energy overflow flag lost");

  a_math_clear:
    assert property (@(posedge mclk) disable iff (!rst_n)
      (conv_trigger && !math_ovf) |=> !arithmetic_overflow_flag_r)
    else $error("arithmetic overflow not cleared by new conversion");

  a_cnv_set:
    assert property (@(posedge mclk) disable iff (!rst_n)
      avg_done |=> conversion_done_flag_r)
    else $error("conversion done flag not set");

  a_temp_low_zero:
    assert property (@(posedge mclk) disable iff (!rst_n)
      (reg_rd && reg_addr == ADDR_TEMP) |=> (reg_rdata_r[3:0] == 4'h0 && reg_rdata_r[39:16] == 24'h00_0000))
    else $error("temperature read has nonzero low or upper bits");

  a_trim_sticky:
    assert property (@(posedge mclk) disable iff (!rst_n)
      trim_checksum_err |=> !trim_checksum_ok_r [*3])
    else $error("trim checksum status recovered");

endmodule // pmra_result_bank

//--- pmra_result_bank_tb.sv
// Self-checking bench for the result registers, diagnostic flags and alert wire
`timescale 1ns/1ps
module pmra_result_bank_tb
  import pmra_pkg::*;
;
  typedef struct packed {
    logic [3:0]  cfg;
    logic [1:0]  sel;
    logic [23:0] val;
    logic [7:0]  ev;
    logic [15:0] diag;
    logic [1:0]  pin;
  } pmra_row_type;

  logic                 mclk = 1'b0;
  logic                 rst_n = 1'b0;
  logic [7:0]           ev = 8'h00;
  logic [W_BUS_V-1:0]   bus_v;
  logic [W_TEMP-1:0]    temp;
  logic [W_CURR-1:0]    curr;
  logic [W_POWER-1:0]   pwr;
  logic [W_ACC-1:0]     energy = 40'h0;
  logic [W_ACC-1:0]     charge = 40'h0;
  logic [5:0]           reg_addr;
  logic                 reg_rd;
  logic                 reg_wr;
  logic [15:0]          reg_wdata;
  logic [W_RDATA-1:0]   rdata;
  logic                 alert_o;
  logic                 alert_oe;
  logic                 alert_pin;
  logic [W_RDATA-1:0]   d;
  int                   err_total = 0;
  int                   compares = 0;
  pmra_row_type         rows [15];
  pmra_row_type         r;

  always #10 mclk = ~mclk;

  pmra_result_bank pmra_result_bank_inst (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_r(rdata), .raw_valid(ev[0]), .avg_done(ev[1]),
    .conv_trigger(ev[2]), .accumulator_clear(ev[3]), .energy_wrap(ev[4]), .charge_wrap(ev[5]),
    .math_ovf(ev[6]), .trim_checksum_err(ev[7]), .bus_v_in(bus_v), .temp_in(temp),
    .curr_in(curr), .power_in(pwr), .energy_in(energy), .charge_in(charge),
    .bus_over_lim(15'h0100), .bus_under_lim(15'h0010), .temp_over_lim(12'h100),
    .curr_over_lim(16'h0100), .curr_under_lim(16'hff00), .power_over_lim(16'h0010),
    .alert_o_r(alert_o), .alert_oe_r(alert_oe));

  pmra_host_model pmra_host_model_inst (
    .mclk(mclk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata_r(rdata), .alert_o_r(alert_o), .alert_oe_r(alert_oe), .alert_pin(alert_pin));

  ////////////////////////////////////////
  task automatic chk(input logic [W_RDATA-1:0] seen, input logic [W_RDATA-1:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [W_RDATA-1:0] e);
    pmra_host_model_inst.rd(a, d);
    chk(d, e);
  endtask

  // Alert follows the flag one cycle later, so look one edge after the event task
  task automatic pinchk(input logic e);
    @(posedge mclk);
    #1 chk({39'h0, alert_pin}, {39'h0, e});
  endtask

  task automatic evt(input logic [7:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 8'h00;
  endtask

  task automatic nominal;
    bus_v <= 16'h0080;
    temp  <= 12'h050;
    curr  <= 16'h0000;
    pwr   <= 24'h00_0100;
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge mclk);
    err_total++;
    results;
  end

  ////////////////////////////////////////
  // Rows: config nibble, value select (bus, temp, curr, power), value, events, DIAG, pin (2 = skip)
  initial
  begin
    rows[0]  = '{4'h8, 2'd1, 24'h00_0200, 8'h01, 16'h8081, 2'd0};
    rows[1]  = '{4'h8, 2'd2, 24'h00_0200, 8'h01, 16'h8041, 2'd0};
    rows[2]  = '{4'h8, 2'd2, 24'h00_fe00, 8'h01, 16'h8021, 2'd0};
    rows[3]  = '{4'h8, 2'd0, 24'h00_0200, 8'h01, 16'h8011, 2'd0};
    rows[4]  = '{4'h8, 2'd0, 24'h00_0008, 8'h01, 16'h8009, 2'd0};
    rows[5]  = '{4'h8, 2'd3, 24'h00_2000, 8'h01, 16'h8005, 2'd0};
    rows[6]  = '{4'h8, 2'd2, 24'h00_0000, 8'h10, 16'h8801, 2'd2};
    rows[7]  = '{4'h8, 2'd2, 24'h00_0000, 8'h20, 16'h8401, 2'd2};
    rows[8]  = '{4'h8, 2'd2, 24'h00_0000, 8'h40, 16'h8201, 2'd2};
    rows[9]  = '{4'hc, 2'd2, 24'h00_0000, 8'h02, 16'hc003, 2'd0};
    rows[10] = '{4'h8, 2'd2, 24'h00_0000, 8'h02, 16'h8003, 2'd1};
    rows[11] = '{4'h9, 2'd2, 24'h00_0200, 8'h01, 16'h9041, 2'd1};
    rows[12] = '{4'ha, 2'd2, 24'h00_0200, 8'h01, 16'ha001, 2'd1};
    rows[13] = '{4'ha, 2'd2, 24'h00_0200, 8'h02, 16'ha043, 2'd0};
    rows[14] = '{4'h0, 2'd2, 24'h00_0200, 8'h01, 16'h0041, 2'd0};
    nominal;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 5; a <= 11; a++) rdchk(6'(a), (a == 11) ? 40'h1 : 40'h0);
    pinchk(1'b1);
    $display("test reset done");
    bus_v  <= 16'h7ffe;
    temp   <= 12'h9ab;
    curr   <= 16'hbeef;
    pwr    <= 24'hff_eeee;
    energy <= 40'h12_3456_789a;
    charge <= 40'h80_0000_0001;
    evt(8'h02);
    rdchk(ADDR_BUS_V, 40'h7ffe);
    rdchk(ADDR_TEMP, 40'h9ab0);
    rdchk(ADDR_CURR, 40'hbeef);
    rdchk(ADDR_POWER, 40'hff_eeee);
    rdchk(ADDR_ENERGY, 40'h12_3456_789a);
    rdchk(ADDR_CHARGE, 40'h80_0000_0001);
    pmra_host_model_inst.wr(ADDR_CURR, 16'h0000);
    rdchk(ADDR_CURR, 40'hbeef);
    rdchk(6'h0c, 40'h0);
    nominal;
    evt(8'h0d);
    rdchk(ADDR_CHARGE, 40'h0);
    rdchk(ADDR_DIAG, 40'h1);
    $display("test results done");
    for (int i = 0; i < 15; i++)
    begin
      r = rows[i];
      pmra_host_model_inst.wr(ADDR_DIAG, {r.cfg, 12'h000});
      bus_v <= (r.sel == 2'd0) ? r.val[15:0] : 16'h0080;
      temp  <= (r.sel == 2'd1) ? r.val[11:0] : 12'h050;
      curr  <= (r.sel == 2'd2) ? r.val[15:0] : 16'h0000;
      pwr   <= (r.sel == 2'd3) ? r.val : 24'h00_0100;
      evt(r.ev);
      if (r.pin != 2'd2) pinchk(r.pin[0]);
      rdchk(ADDR_DIAG, {24'h0, r.diag});
      nominal;
      evt(8'h0d);
      rdchk(ADDR_DIAG, {24'h0, r.cfg, 12'h001});
      pinchk(~r.cfg[0]);
      $display("test row %0d done", i);
    end
    // A transparent read must not clear; a latched read must
    pmra_host_model_inst.wr(ADDR_DIAG, 16'h0000);
    curr <= 16'h0200;
    evt(8'h01);
    rdchk(ADDR_DIAG, 40'h0041);
    rdchk(ADDR_DIAG, 40'h0041);
    pmra_host_model_inst.wr(ADDR_DIAG, 16'h8000);
    evt(8'h01);
    rdchk(ADDR_DIAG, 40'h8041);
    rdchk(ADDR_DIAG, 40'h8001);
    pinchk(1'b1);
    evt(8'h42);
    evt(8'h04);
    rdchk(ADDR_DIAG, 40'h8001);
    $display("test latch done");
    evt(8'h80);
    rdchk(ADDR_DIAG, 40'h8000);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(ADDR_DIAG, 40'h1);
    $display("test trim done");
    results;
  end
endmodule // pmra_result_bank_tb
